// ==== verilog/dit_pkg.sv ====
// constants and carrier types for the drive input terminal decoder
// assumes a single 250 MHz clock and synchronous active-low reset
//
// Notes on behaviour
// - four reference terminals form a 4-bit index, fourth is msb, all off is 0
// - a preset of 100 percent scales to the maximum output frequency
// - two ramp terminals pick time set 1 to 4 as a binary code plus one
// - each terminal is filtered, time 0.000 to 1.000 s, default 0.010 s
// - command mode: 0 two-line 1, 1 two-line 2, 2 three-line 1, 3 three-line 2
// - two-line 1: forward alone runs forward, reverse alone reverse, equal stops
// - both two-line modes act on filtered levels, not edges
// - two-line 2: first enables run, second picks reverse, first off stops
// - function 43 selects the second pid gain set while on, if enabled
// - function 46 toggles speed/torque mode against the configured one
// - function 48 decelerates to stop on time set 4 in any command source
// - function 49 decelerates to dc brake start frequency, then dc brakes
// - function 50 clears the running time counter if running time is enabled
// - three-line 1: enable level must be on; forward/reverse rising edges start
package dit_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int FILTER_MAX_US = 1000000;
    localparam int FILTER_DEFAULT_US = 10000;
    localparam int CYCLES_PER_US = CLK_MHZ;
    localparam int FILTER_DEFAULT_CYCLES = FILTER_DEFAULT_US * CYCLES_PER_US;
    localparam int FILTER_MAX_CYCLES = FILTER_MAX_US * CYCLES_PER_US;
    localparam int FILTER_CNT_W = 28;
    localparam int SYNC_STAGES = 3;

    // ----------------------------------------------------------------
    // terminal functions
    // ----------------------------------------------------------------
    localparam logic [5:0] FN_NONE = 6'h00;
    localparam logic [5:0] FN_FORWARD = 6'h01;
    localparam logic [5:0] FN_REVERSE = 6'h02;
    localparam logic [5:0] FN_THREE_WIRE = 6'h03;
    localparam logic [5:0] FN_REF_BIT0 = 6'h0c;
    localparam logic [5:0] FN_REF_BIT1 = 6'h0d;
    localparam logic [5:0] FN_REF_BIT2 = 6'h0e;
    localparam logic [5:0] FN_REF_BIT3 = 6'h0f;
    localparam logic [5:0] FN_RAMP_BIT0 = 6'h10;
    localparam logic [5:0] FN_RAMP_BIT1 = 6'h11;
    localparam logic [5:0] FN_PID_GAIN = 6'h2b;
    localparam logic [5:0] FN_RESERVED_A = 6'h2c;
    localparam logic [5:0] FN_RESERVED_B = 6'h2d;
    localparam logic [5:0] FN_SPEED_TORQUE = 6'h2e;
    localparam logic [5:0] FN_EMERGENCY = 6'h2f;
    localparam logic [5:0] FN_EXT_STOP2 = 6'h30;
    localparam logic [5:0] FN_DECEL_DC = 6'h31;
    localparam logic [5:0] FN_CLEAR_RUNTIME = 6'h32;

    // ----------------------------------------------------------------
    // modes and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_TWO_LINE_1 = 2'h0;
    localparam logic [1:0] MODE_TWO_LINE_2 = 2'h1;
    localparam logic [1:0] MODE_THREE_LINE_1 = 2'h2;
    localparam logic [1:0] MODE_THREE_LINE_2 = 2'h3;
    localparam logic [1:0] RAMP_SET_4 = 2'h3;
    localparam int REF_PERCENT_FULL = 10000;

    typedef enum logic [2:0] {
        DIT_STOP = 3'b001,
        DIT_FORWARD = 3'b010,
        DIT_REVERSE = 3'b100
    } dit_run_t;

    typedef struct packed {
        logic run;
        logic reverse;
        logic [3:0] reference_index;
        logic [1:0] ramp_set;
        logic pid_second_gain;
        logic torque_mode;
        logic emergency_stop;
        logic decel_stop;
        logic decel_dc_brake;
        logic clear_runtime;
    } dit_cmd_t;

endpackage

// ==== verilog/dit_filter.sv ====
// one terminal: three-stage synchroniser and hold-time filter
// assumes the raw input is asynchronous to clk
`timescale 1ns/10ps
module dit_filter #(
    parameter int CNT_W = 28
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic raw,
    input wire logic [CNT_W-1:0] hold_cycles,
    output logic level
);

    logic [2:0] sync;
    logic [CNT_W-1:0] count;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            sync <= 3'h0;
        else
            sync <= {sync[1:0], raw};
    end

    // stage 0 is read only by stage 1; a change counts once stages 1 and 2 agree
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            count <= '0;
            level <= 1'b0;
        end
        else if (sync[2] != sync[1] || sync[2] == level)
            count <= '0;
        else if (count >= hold_cycles)
        begin
            level <= sync[2];
            count <= '0;
        end
        else
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
    end

endmodule // dit_filter

// ==== verilog/dit_decoder.sv ====
// top of the terminal decoder: filters terminals, decodes functions
// assumes terminal functions and settings are held steady by the configuring logic
`timescale 1ns/10ps
module dit_decoder #(
    parameter int TERMINALS = 8,
    parameter int REF_W = 16,
    parameter int FREQ_W = 16,
    parameter int FILTER_CYCLES = dit_pkg::FILTER_DEFAULT_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [TERMINALS-1:0] terminal_raw,
    input wire logic [TERMINALS*6-1:0] terminal_function,
    input wire logic [dit_pkg::FILTER_CNT_W-1:0] input_filter_time,
    input wire logic [1:0] terminal_command_mode,
    input wire logic pid_gain_switch_source,
    input wire logic speed_torque_mode_select,
    input wire logic runtime_feature_enable,
    input wire logic [16*REF_W-1:0] preset_reference_zero,
    input wire logic [FREQ_W-1:0] max_output_frequency,
    output logic [TERMINALS-1:0] terminal_level,
    output dit_pkg::dit_cmd_t command,
    output logic [FREQ_W-1:0] reference_frequency
);

    // ----------------------------------------------------------------
    // filtering
    // ----------------------------------------------------------------
    logic [dit_pkg::FILTER_CNT_W-1:0] hold_cycles;

    // filter time is given in clock cycles; values past 1 s are clamped
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            hold_cycles <= dit_pkg::FILTER_CNT_W'(FILTER_CYCLES);
        else if (input_filter_time > dit_pkg::FILTER_CNT_W'(dit_pkg::FILTER_MAX_CYCLES))
            hold_cycles <= dit_pkg::FILTER_CNT_W'(dit_pkg::FILTER_MAX_CYCLES);
        else
            hold_cycles <= input_filter_time;
    end

    genvar gi;
    generate
        for (gi = 0; gi < TERMINALS; gi++)
        begin : g_filter
            dit_filter #(
                .CNT_W(dit_pkg::FILTER_CNT_W)
            ) u_filter (
                .clk(clk),
                .reset_n(reset_n),
                .raw(terminal_raw[gi]),
                .hold_cycles(hold_cycles),
                .level(terminal_level[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // function gathering
    // ----------------------------------------------------------------
    // any terminal carrying the function and on counts; unused codes fall out
    function automatic logic fn_on(input logic [TERMINALS*6-1:0] fns,
                                   input logic [TERMINALS-1:0] lv,
                                   input logic [5:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < TERMINALS; i++)
            if (fns[i*6 +: 6] == code && lv[i])
                hit = 1'b1;
        return hit;
    endfunction

    logic forward_run_terminal;
    logic reverse_run_terminal;
    logic three_wire_enable_terminal;
    logic [3:0] ref_bits;
    logic [1:0] ramp_bits;
    logic pid_term;
    logic torque_term;
    logic emergency_term;
    logic stop2_term;
    logic decel_dc_term;
    logic clear_term;

    // reserved codes 44 and 45 are never matched, so they do nothing
    always_comb
    begin
        forward_run_terminal = fn_on(terminal_function, terminal_level, dit_pkg::FN_FORWARD);
        reverse_run_terminal = fn_on(terminal_function, terminal_level, dit_pkg::FN_REVERSE);
        three_wire_enable_terminal = fn_on(terminal_function, terminal_level,
                                           dit_pkg::FN_THREE_WIRE);
        ref_bits[0] = fn_on(terminal_function, terminal_level, dit_pkg::FN_REF_BIT0);
        ref_bits[1] = fn_on(terminal_function, terminal_level, dit_pkg::FN_REF_BIT1);
        ref_bits[2] = fn_on(terminal_function, terminal_level, dit_pkg::FN_REF_BIT2);
        ref_bits[3] = fn_on(terminal_function, terminal_level, dit_pkg::FN_REF_BIT3);
        ramp_bits[0] = fn_on(terminal_function, terminal_level, dit_pkg::FN_RAMP_BIT0);
        ramp_bits[1] = fn_on(terminal_function, terminal_level, dit_pkg::FN_RAMP_BIT1);
        pid_term = fn_on(terminal_function, terminal_level, dit_pkg::FN_PID_GAIN);
        torque_term = fn_on(terminal_function, terminal_level, dit_pkg::FN_SPEED_TORQUE);
        emergency_term = fn_on(terminal_function, terminal_level, dit_pkg::FN_EMERGENCY);
        stop2_term = fn_on(terminal_function, terminal_level, dit_pkg::FN_EXT_STOP2);
        decel_dc_term = fn_on(terminal_function, terminal_level, dit_pkg::FN_DECEL_DC);
        clear_term = fn_on(terminal_function, terminal_level, dit_pkg::FN_CLEAR_RUNTIME);
    end

    // ----------------------------------------------------------------
    // run state machine
    // ----------------------------------------------------------------
    dit_pkg::dit_run_t run_state;
    dit_pkg::dit_run_t next_run_state;
    logic forward_prev;
    logic reverse_prev;
    logic forward_rise;
    logic reverse_rise;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            forward_prev <= 1'b0;
            reverse_prev <= 1'b0;
        end
        else
        begin
            forward_prev <= forward_run_terminal;
            reverse_prev <= reverse_run_terminal;
        end
    end

    assign forward_rise = forward_run_terminal && !forward_prev;
    assign reverse_rise = reverse_run_terminal && !reverse_prev;

    always_comb
    begin
        next_run_state = run_state;
        case (terminal_command_mode)
            dit_pkg::MODE_TWO_LINE_1:
            begin
                // levels only, so a held switch restarts after a stop
                if (forward_run_terminal && !reverse_run_terminal)
                    next_run_state = dit_pkg::DIT_FORWARD;
                else if (!forward_run_terminal && reverse_run_terminal)
                    next_run_state = dit_pkg::DIT_REVERSE;
                else
                    next_run_state = dit_pkg::DIT_STOP;
            end
            dit_pkg::MODE_TWO_LINE_2:
            begin
                if (!forward_run_terminal)
                    next_run_state = dit_pkg::DIT_STOP;
                else if (reverse_run_terminal)
                    next_run_state = dit_pkg::DIT_REVERSE;
                else
                    next_run_state = dit_pkg::DIT_FORWARD;
            end
            default:
            begin
                // three-line: edges start, enable level must stay on
                if (!three_wire_enable_terminal)
                    next_run_state = dit_pkg::DIT_STOP;
                else if (forward_rise)
                    next_run_state = dit_pkg::DIT_FORWARD;
                else if (reverse_rise)
                    next_run_state = dit_pkg::DIT_REVERSE;
            end
        endcase
        // emergency, stop-2 and decel-dc-brake override any command source
        if (emergency_term || stop2_term || decel_dc_term)
            next_run_state = dit_pkg::DIT_STOP;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            run_state <= dit_pkg::DIT_STOP;
        else
            run_state <= next_run_state;
    end

    // ----------------------------------------------------------------
    // command outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            command <= '0;
        else
        begin
            command.run <= (run_state != dit_pkg::DIT_STOP);
            command.reverse <= (run_state == dit_pkg::DIT_REVERSE);
            command.reference_index <= ref_bits;
            // stop-2 forces deceleration time set 4
            command.ramp_set <= stop2_term ? dit_pkg::RAMP_SET_4 : ramp_bits;
            command.pid_second_gain <= pid_gain_switch_source && pid_term;
            command.torque_mode <= speed_torque_mode_select ^ torque_term;
            command.emergency_stop <= emergency_term;
            command.decel_stop <= stop2_term;
            command.decel_dc_brake <= decel_dc_term;
            command.clear_runtime <= runtime_feature_enable && clear_term;
        end
    end

    // ----------------------------------------------------------------
    // reference scaling
    // ----------------------------------------------------------------
    logic [REF_W-1:0] selected_ref;
    logic [REF_W+FREQ_W-1:0] scaled;

    // presets are in 0.01 percent units; 10000 maps to full scale
    assign selected_ref = preset_reference_zero[ref_bits*REF_W +: REF_W];
    assign scaled = (selected_ref * max_output_frequency)
                  / (REF_W+FREQ_W)'(dit_pkg::REF_PERCENT_FULL);

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            reference_frequency <= '0;
        else
            reference_frequency <= scaled[FREQ_W-1:0];
    end

endmodule // dit_decoder

// ==== test/dit_decoder_asserts.sv ====
// port checker for the terminal decoder
// assumes filter times of at least 4 cycles and a steady function map
`timescale 1ns/10ps
module dit_decoder_asserts #(
    parameter int TERMINALS = 8,
    parameter int REF_W = 16,
    parameter int FREQ_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [TERMINALS-1:0] terminal_raw,
    input wire logic [TERMINALS*6-1:0] terminal_function,
    input wire logic [dit_pkg::FILTER_CNT_W-1:0] input_filter_time,
    input wire logic [1:0] terminal_command_mode,
    input wire logic pid_gain_switch_source,
    input wire logic speed_torque_mode_select,
    input wire logic runtime_feature_enable,
    input wire logic [16*REF_W-1:0] preset_reference_zero,
    input wire logic [FREQ_W-1:0] max_output_frequency,
    input wire logic [TERMINALS-1:0] terminal_level,
    input wire dit_pkg::dit_cmd_t command,
    input wire logic [FREQ_W-1:0] reference_frequency
);
    // ----------------------------------------------------------------
    // functions active on the filtered terminals
    // ----------------------------------------------------------------
    logic [63:0] on_q;
    logic [2:0] ctx;
    logic [31:0] exp_freq;
    always_comb
    begin
        on_q = 64'h0;
        for (int i = 0; i < TERMINALS; i++)
            if (terminal_level[i])
                on_q[terminal_function[i*6+:6]] = 1'b1;
    end
    // run decode is only judged while no stop function overrides it
    assign ctx = {!(on_q[47] | on_q[48] | on_q[49]), terminal_command_mode};
    assign exp_freq = 32'(preset_reference_zero[on_q[15:12]*REF_W+:REF_W])
        * 32'(max_output_frequency) / 32'h2710;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    ref_index_a: assert property ($past(reset_n)
        |-> command.reference_index == $past(on_q[15:12]))
        else $error("reference index wrong");
    ramp_set_a: assert property ($past(reset_n)
        |-> command.ramp_set == ($past(on_q[48]) ? 2'h3 : $past(on_q[17:16])))
        else $error("ramp set wrong");
    gain_mode_a: assert property ($past(reset_n)
        |-> {command.pid_second_gain, command.torque_mode}
        == $past({on_q[43] & pid_gain_switch_source, on_q[46] ^ speed_torque_mode_select}))
        else $error("gain or control mode wrong");
    stop_flags_a: assert property ($past(reset_n)
        |-> command[3:0]
        == $past({on_q[47], on_q[48], on_q[49], on_q[50] & runtime_feature_enable}))
        else $error("stop flags wrong");
    two_line_one_a: assert property ($past(ctx) == 3'h4 && $past(ctx, 2) == 3'h4
        |-> command.run == $past(on_q[1] ^ on_q[2], 2)
        && (!command.run || command.reverse == $past(on_q[2], 2)))
        else $error("two-line mode 1 run wrong");
    two_line_two_a: assert property ($past(ctx) == 3'h5 && $past(ctx, 2) == 3'h5
        |-> command.run == $past(on_q[1], 2)
        && (!command.run || command.reverse == $past(on_q[2], 2)))
        else $error("two-line mode 2 run wrong");
    three_line_a: assert property ($past(terminal_command_mode, 2) >= 2'h2
        && !$past(on_q[3], 2) |-> !command.run)
        else $error("three-line run without enable");
    ref_freq_a: assert property ($past(reset_n)
        |-> reference_frequency == $past(exp_freq[FREQ_W-1:0]))
        else $error("reference frequency wrong");
    filter_hold_a: assert property ($changed(terminal_level[0])
        |-> $past(terminal_raw[0], 3) == terminal_level[0]
        && $past(terminal_raw[0], 5) == terminal_level[0])
        else $error("terminal level changed without held input");
endmodule // dit_decoder_asserts
bind dit_decoder dit_decoder_asserts #(.TERMINALS(TERMINALS), .REF_W(REF_W), .FREQ_W(FREQ_W))
    dit_decoder_asserts_i (.clk(clk), .reset_n(reset_n), .terminal_raw(terminal_raw),
    .terminal_function(terminal_function), .input_filter_time(input_filter_time),
    .terminal_command_mode(terminal_command_mode), .pid_gain_switch_source(pid_gain_switch_source),
    .speed_torque_mode_select(speed_torque_mode_select),
    .runtime_feature_enable(runtime_feature_enable), .preset_reference_zero(preset_reference_zero),
    .max_output_frequency(max_output_frequency), .terminal_level(terminal_level),
    .command(command), .reference_frequency(reference_frequency));

// ==== test/dit_switches.sv ====
// switches on the terminals: wanted levels, with optional contact bounce
// assumes the bench moves want and bounce just after a rising edge
`timescale 1ns/10ps
module dit_switches (
    input wire logic clk,
    input wire logic [15:0] want,
    input wire logic [15:0] bounce,
    output logic [15:0] raw
);
    initial raw = 16'h0000;
    // a set bounce bit flips the contact, as a short noise pulse would
    always @(posedge clk)
    begin
        raw <= want ^ bounce;
    end
endmodule // dit_switches

// ==== test/dit_decoder_tb.sv ====
// self-checking bench for the terminal decoder
// assumes 16 terminals, one of each function, and a 4-cycle filter, raised to 20 cycles for the last check
`timescale 1ns/10ps
module dit_decoder_tb;
    typedef struct packed {
        logic [15:0] raw;
        logic [1:0] mode;
        logic [2:0] cfg;
        dit_pkg::dit_cmd_t cmd;
        logic [15:0] freq;
    } dit_row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] want = 16'h0000;
    logic [15:0] bounce = 16'h0000;
    logic [15:0] raw;
    logic [27:0] filt = 28'h0000004;
    logic [1:0] mode = 2'h0;
    logic [2:0] cfg = 3'h0;
    logic [255:0] presets;
    logic [15:0] level;
    logic [15:0] freq;
    dit_pkg::dit_cmd_t cmd;
    int num_errors = 0;
    int n_compared = 0;
    dit_row_t rows [20];
    always #2 clk = ~clk;
    dit_switches dit_switches_i (.clk(clk), .want(want), .bounce(bounce), .raw(raw));
    dit_decoder #(.TERMINALS(16), .REF_W(16), .FREQ_W(16), .FILTER_CYCLES(4)) dit_decoder_i (
        .clk(clk), .reset_n(reset_n), .terminal_raw(raw),
        .terminal_function({6'h32, 6'h31, 6'h30, 6'h2f, 6'h2e, 6'h2c, 6'h2b, 6'h11,
            6'h10, 6'h0f, 6'h0e, 6'h0d, 6'h0c, 6'h03, 6'h02, 6'h01}),
        .input_filter_time(filt), .terminal_command_mode(mode), .pid_gain_switch_source(cfg[2]),
        .speed_torque_mode_select(cfg[1]), .runtime_feature_enable(cfg[0]),
        .preset_reference_zero(presets), .max_output_frequency(16'h3e80),
        .terminal_level(level), .command(cmd), .reference_frequency(freq));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apply(input logic [15:0] w, input logic [1:0] m, input logic [2:0] c);
        @(posedge clk);
        want <= w;
        mode <= m;
        cfg <= c;
        repeat (16) @(posedge clk);
        #1;
    endtask
    // direction is meaningless while stopped, so it is not compared then
    function automatic logic [13:0] masked(input logic [13:0] c);
        return c[13] ? c : (c & 14'h2fff);
    endfunction
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        summarize();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        for (int n = 0; n < 16; n++)
            presets[n*16+:16] = 16'(n * 500);
        presets[255:240] = 16'h2710;
        rows = '{{16'h0001, 2'h0, 3'h0, 14'h2000, 16'h0000},
            {16'h0002, 2'h0, 3'h0, 14'h3000, 16'h0000}, {16'h0003, 2'h0, 3'h0, 14'h0000, 16'h0000},
            {16'h0001, 2'h1, 3'h0, 14'h2000, 16'h0000}, {16'h0003, 2'h1, 3'h0, 14'h3000, 16'h0000},
            {16'h0002, 2'h1, 3'h0, 14'h0000, 16'h0000}, {16'h0078, 2'h0, 3'h0, 14'h0f00, 16'h3e80},
            {16'h0048, 2'h0, 3'h0, 14'h0900, 16'h1c20}, {16'h0080, 2'h0, 3'h0, 14'h0040, 16'h0000},
            {16'h0100, 2'h0, 3'h0, 14'h0080, 16'h0000}, {16'h0180, 2'h0, 3'h0, 14'h00c0, 16'h0000},
            {16'h0200, 2'h0, 3'h4, 14'h0020, 16'h0000}, {16'h0200, 2'h0, 3'h0, 14'h0000, 16'h0000},
            {16'h0a00, 2'h0, 3'h6, 14'h0020, 16'h0000}, {16'h0000, 2'h0, 3'h2, 14'h0010, 16'h0000},
            {16'h1001, 2'h0, 3'h0, 14'h0008, 16'h0000}, {16'h2001, 2'h0, 3'h0, 14'h00c4, 16'h0000},
            {16'h4001, 2'h0, 3'h0, 14'h0002, 16'h0000}, {16'h8000, 2'h0, 3'h1, 14'h0001, 16'h0000},
            {16'h0401, 2'h0, 3'h0, 14'h2000, 16'h0000}};
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[i])
        begin
            apply(rows[i].raw, rows[i].mode, rows[i].cfg);
            check(32'(masked(cmd)), 32'(masked(rows[i].cmd)));
            check(32'(freq), 32'(rows[i].freq));
        end
        // reset in mid-run clears everything, then the filter retimes
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check(32'({cmd, level}), 32'h0);
        @(posedge clk);
        reset_n <= 1'b1;
        apply(16'h0001, 2'h0, 3'h0);
        check(32'(cmd.run), 32'h1);
        for (int m = 2; m < 4; m++)
        begin
            apply(16'h0004, 2'(m), 3'h0);
            check(32'(cmd.run), 32'h0);
            apply(16'h0005, 2'(m), 3'h0);
            apply(16'h0004, 2'(m), 3'h0);
            check(32'({cmd.run, cmd.reverse}), 32'h2);
            apply(16'h0006, 2'(m), 3'h0);
            apply(16'h0004, 2'(m), 3'h0);
            check(32'({cmd.run, cmd.reverse}), 32'h3);
            apply(16'h0000, 2'(m), 3'h0);
            check(32'(cmd.run), 32'h0);
        end
        // a two-cycle bounce is shorter than the filter and must vanish
        apply(16'h0000, 2'h0, 3'h0);
        @(posedge clk);
        bounce <= 16'h0001;
        repeat (2) @(posedge clk);
        bounce <= 16'h0000;
        repeat (20) @(posedge clk);
        #1;
        check(32'(level[0]), 32'h0);
        @(posedge clk);
        filt <= 28'h0000014;
        apply(16'h0000, 2'h0, 3'h0);
        @(posedge clk);
        want <= 16'h0001;
        repeat (15) @(posedge clk);
        #1;
        check(32'(level[0]), 32'h0);
        repeat (20) @(posedge clk);
        #1;
        check(32'(level[0]), 32'h1);
        summarize();
    end
endmodule // dit_decoder_tb
